/* common/rmc_pkg.sv */
// Shared constants for the reset-time configuration capture block.
// Assumes the strap encodings below are fixed for every instance of the block.
package rmc_pkg;

    // Topology select codes.
    localparam logic [1:0] RMC_TOPO_DEMUX = 2'h0;
    localparam logic [1:0] RMC_TOPO_BCAST = 2'h1;
    localparam logic [1:0] RMC_TOPO_MUX = 2'h2;
    localparam logic [1:0] RMC_TOPO_RESTRICTED = 2'h3;

    // Port width select codes.
    localparam logic [1:0] RMC_WIDTH_X10 = 2'h0;
    localparam logic [1:0] RMC_WIDTH_X20 = 2'h1;
    localparam logic [1:0] RMC_WIDTH_X40 = 2'h2;
    localparam logic [1:0] RMC_WIDTH_RESTRICTED = 2'h3;

    // Port widths in bits, as reported on the width outputs.
    localparam int RMC_WIDTH_BITS_W = 6;
    localparam logic [5:0] RMC_BITS_10 = 6'h0a;
    localparam logic [5:0] RMC_BITS_20 = 6'h14;
    localparam logic [5:0] RMC_BITS_40 = 6'h28;

    // Offset default select codes and the offsets they load.
    localparam int RMC_OFFSET_W = 10;
    localparam int RMC_NUM_QUEUES = 4;
    localparam logic [1:0] RMC_OFS_SEL_7 = 2'h0;
    localparam logic [1:0] RMC_OFS_SEL_63 = 2'h1;
    localparam logic [1:0] RMC_OFS_SEL_127 = 2'h2;
    localparam logic [1:0] RMC_OFS_SEL_1023 = 2'h3;
    localparam logic [9:0] RMC_OFS_7 = 10'h007;
    localparam logic [9:0] RMC_OFS_63 = 10'h03f;
    localparam logic [9:0] RMC_OFS_127 = 10'h07f;
    localparam logic [9:0] RMC_OFS_1023 = 10'h3ff;

    // Values held after the asynchronous reset, before any master reset.
    localparam logic [1:0] RMC_RST_TOPO = RMC_TOPO_DEMUX;
    localparam logic [5:0] RMC_RST_BITS = RMC_BITS_10;
    localparam logic [9:0] RMC_RST_OFS = RMC_OFS_7;
    localparam logic [1:0] RMC_RST_QUEUE = 2'h0;

endpackage

/* rtl/rmc_config_capture.sv */
// Reset-time configuration capture for a four-queue mux/demux/broadcast buffer.
// Assumes every strap and master_reset_n are synchronous to ref_clk.
//
// Operation
// R1: Board logic holds every strap steady throughout the master reset pulse.
// R2: Topology, timing, rates, widths, offsets and queues come from straps at master reset.
// R3: Topology code 00 demux, 10 mux, 01 broadcast, 11 restricted.
// R4: Flag timing strap low selects standard timing, high selects fall-through timing.
// R5: Write rate strap low is single rate, high double, for all write ports.
// R6: Read rate strap low is single rate, high double, for all read ports.
// R7: Synchronous flag mode double-registers almost-empty and almost-full flags.
// R8: Asynchronous flag mode passes flags straight from occupancy counters; here they pass through one register stage.
// R9: Demux and broadcast follow write width select; read ports stay 10 bits.
// R10: Write width code 00 is 10, 01 is 20, 10 is 40, 11 restricted.
// R11: Mux follows read width select; all write ports stay 10 bits.
// R12: Read width code 00 is 10, 01 is 20, 10 is 40, 11 restricted.
// R13: Offset default select loads 7, 63, 127 or 1023 at master reset.
// R14: Input queue select applies in demux only; output queue select in mux only.
// R15: First write and first read after master reset target the selected queues.
// R16: The default offset is applied identically to all four queues.
// R17: Captured configuration stays constant until the next master reset pulse.
// R18: Board logic never drives restricted topology or width codes at master reset.
`timescale 1ns/1ps

module rmc_config_capture
    import rmc_pkg::*;
#(
    parameter int NUM_QUEUES = RMC_NUM_QUEUES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Master reset and configuration straps.
    input wire logic master_reset_n,
    input wire logic [1:0] topology_select,
    input wire logic flag_timing_serial_in,
    input wire logic write_rate_select,
    input wire logic read_rate_select,
    input wire logic prog_flag_timing_select,
    input wire logic [1:0] write_width_select,
    input wire logic [1:0] read_width_select,
    input wire logic [1:0] offset_default_select,
    input wire logic [1:0] input_queue_select,
    input wire logic [1:0] output_queue_select,
    // Raw flag levels from the per-queue occupancy counters.
    input wire logic [NUM_QUEUES-1:0] empty_level_raw,
    input wire logic [NUM_QUEUES-1:0] full_level_raw,
    // Captured configuration.
    output logic mux_mode,
    output logic demux_mode,
    output logic broadcast_mode,
    output logic fall_through_timing,
    output logic write_ddr,
    output logic read_ddr,
    output logic prog_flag_sync,
    output logic [RMC_WIDTH_BITS_W-1:0] write_port_bits,
    output logic [RMC_WIDTH_BITS_W-1:0] read_port_bits,
    output logic [NUM_QUEUES*RMC_OFFSET_W-1:0] flag_offsets,
    output logic [1:0] write_queue,
    output logic [1:0] read_queue,
    output logic config_restricted,
    output logic config_valid,
    // Programmable flags.
    output logic [NUM_QUEUES-1:0] almost_empty_flag,
    output logic [NUM_QUEUES-1:0] almost_full_flag
);

    // Width code to bit count; restricted codes fall back to the narrowest port.
    function automatic logic [RMC_WIDTH_BITS_W-1:0] width_bits(input logic [1:0] code);
        logic [RMC_WIDTH_BITS_W-1:0] bits;
        bits = RMC_BITS_10;
        unique case (code)
            RMC_WIDTH_X10: bits = RMC_BITS_10;
            RMC_WIDTH_X20: bits = RMC_BITS_20;
            RMC_WIDTH_X40: bits = RMC_BITS_40;
            RMC_WIDTH_RESTRICTED: bits = RMC_BITS_10;
        endcase
        return bits;
    endfunction

    // Offset default select to offset value.
    function automatic logic [RMC_OFFSET_W-1:0] default_offset(input logic [1:0] code);
        logic [RMC_OFFSET_W-1:0] ofs;
        ofs = RMC_OFS_7;
        unique case (code)
            RMC_OFS_SEL_7: ofs = RMC_OFS_7;
            RMC_OFS_SEL_63: ofs = RMC_OFS_63;
            RMC_OFS_SEL_127: ofs = RMC_OFS_127;
            RMC_OFS_SEL_1023: ofs = RMC_OFS_1023;
        endcase
        return ofs;
    endfunction

    logic mux_q, mux_d;
    logic demux_q, demux_d;
    logic bcast_q, bcast_d;
    logic fall_through_timing_q, fall_through_timing_d;
    logic write_rate_select_q, write_rate_select_d;
    logic read_rate_select_q, read_rate_select_d;
    logic pflag_sync_q, pflag_sync_d;
    logic [RMC_WIDTH_BITS_W-1:0] wbits_q, wbits_d;
    logic [RMC_WIDTH_BITS_W-1:0] rbits_q, rbits_d;
    logic [RMC_OFFSET_W-1:0] ofs_q, ofs_d;
    logic [1:0] wqueue_q, wqueue_d;
    logic [1:0] rqueue_q, rqueue_d;
    logic restricted_q, restricted_d;
    logic valid_q, valid_d;
    logic in_reset_q, in_reset_d;
    logic is_mux;

    // Decoded topology of the straps now present.
    assign is_mux = (topology_select == RMC_TOPO_MUX);

    // Sample the straps every cycle of the master reset pulse, so the level
    // just before release wins; outside the pulse every captured strap value is held.
    always_comb begin
        mux_d = mux_q;
        demux_d = demux_q;
        bcast_d = bcast_q;
        fall_through_timing_d = fall_through_timing_q;
        write_rate_select_d = write_rate_select_q;
        read_rate_select_d = read_rate_select_q;
        pflag_sync_d = pflag_sync_q;
        wbits_d = wbits_q;
        rbits_d = rbits_q;
        ofs_d = ofs_q;
        wqueue_d = wqueue_q;
        rqueue_d = rqueue_q;
        restricted_d = restricted_q;
        in_reset_d = !master_reset_n;
        valid_d = valid_q;
        if (!master_reset_n) begin
            // R2 capture during reset
            // R3 topology code decoded
            // Mode flags are decoded here so the outputs come straight from registers;
            // a restricted code leaves all three low.
            mux_d = is_mux;
            demux_d = (topology_select == RMC_TOPO_DEMUX);
            bcast_d = (topology_select == RMC_TOPO_BCAST);
            // R4 flag timing style
            fall_through_timing_d = flag_timing_serial_in;
            // R5 write data rate
            write_rate_select_d = write_rate_select;
            // R6 read data rate
            read_rate_select_d = read_rate_select;
            pflag_sync_d = prog_flag_timing_select;
            if (is_mux) begin
                // R11 mux port widths
                // R12 read width decode
                rbits_d = width_bits(read_width_select);
                wbits_d = RMC_BITS_10;
            end else begin
                // R9 demux/broadcast port widths
                // R10 write width decode
                wbits_d = width_bits(write_width_select);
                rbits_d = RMC_BITS_10;
            end
            // R13 default offset load
            ofs_d = default_offset(offset_default_select);
            // R14 queue selects by topology
            wqueue_d = (topology_select == RMC_TOPO_DEMUX) ? input_queue_select : RMC_RST_QUEUE;
            rqueue_d = is_mux ? output_queue_select : RMC_RST_QUEUE;
            // A restricted code gives an unusable setup; it is flagged rather than
            // silently remapped so the board fault is visible.
            restricted_d = (topology_select == RMC_TOPO_RESTRICTED)
                || (is_mux && read_width_select == RMC_WIDTH_RESTRICTED)
                || (!is_mux && write_width_select == RMC_WIDTH_RESTRICTED);
            valid_d = 1'b0;
        end else if (in_reset_q) begin
            // R17 hold after release
            valid_d = 1'b1;
        end
    end

    // Configuration registers.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_q <= (RMC_RST_TOPO == RMC_TOPO_MUX);
            demux_q <= (RMC_RST_TOPO == RMC_TOPO_DEMUX);
            bcast_q <= (RMC_RST_TOPO == RMC_TOPO_BCAST);
            fall_through_timing_q <= 1'b0;
            write_rate_select_q <= 1'b0;
            read_rate_select_q <= 1'b0;
            pflag_sync_q <= 1'b0;
            wbits_q <= RMC_RST_BITS;
            rbits_q <= RMC_RST_BITS;
            ofs_q <= RMC_RST_OFS;
            wqueue_q <= RMC_RST_QUEUE;
            rqueue_q <= RMC_RST_QUEUE;
            restricted_q <= 1'b0;
            valid_q <= 1'b0;
            in_reset_q <= 1'b0;
        end else begin
            mux_q <= mux_d;
            demux_q <= demux_d;
            bcast_q <= bcast_d;
            fall_through_timing_q <= fall_through_timing_d;
            write_rate_select_q <= write_rate_select_d;
            read_rate_select_q <= read_rate_select_d;
            pflag_sync_q <= pflag_sync_d;
            wbits_q <= wbits_d;
            rbits_q <= rbits_d;
            ofs_q <= ofs_d;
            wqueue_q <= wqueue_d;
            rqueue_q <= rqueue_d;
            restricted_q <= restricted_d;
            valid_q <= valid_d;
            in_reset_q <= in_reset_d;
        end
    end

    // Configuration outputs, each straight from its register.
    assign mux_mode = mux_q;
    assign demux_mode = demux_q;
    assign broadcast_mode = bcast_q;
    assign fall_through_timing = fall_through_timing_q;
    assign write_ddr = write_rate_select_q;
    assign read_ddr = read_rate_select_q;
    assign prog_flag_sync = pflag_sync_q;
    assign write_port_bits = wbits_q;
    assign read_port_bits = rbits_q;
    // R15 initial queue targets
    assign write_queue = wqueue_q;
    assign read_queue = rqueue_q;
    assign config_restricted = restricted_q;
    assign config_valid = valid_q;

    // R16 same offset per queue
    // One stored offset feeds every queue, which saves three registers.
    generate
        for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_ofs
            assign flag_offsets[q*RMC_OFFSET_W +: RMC_OFFSET_W] = ofs_q;
        end
    endgenerate

    logic [NUM_QUEUES-1:0] ae_s1_q, ae_s1_d, ae_s2_q, ae_s2_d;
    logic [NUM_QUEUES-1:0] af_s1_q, af_s1_d, af_s2_q, af_s2_d;

    // Flag path: the second stage always registers the flag outputs so that
    // outputs stay registered; synchronous mode adds the first stage in front.
    always_comb begin
        ae_s1_d = empty_level_raw;
        af_s1_d = full_level_raw;
        if (pflag_sync_q) begin
            // R7 double-registered flags
            ae_s2_d = ae_s1_q;
            af_s2_d = af_s1_q;
        end else begin
            // R8 bypass first stage
            ae_s2_d = empty_level_raw;
            af_s2_d = full_level_raw;
        end
    end

    // Flag registers; both flags are inactive during reset.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ae_s1_q <= '0;
            af_s1_q <= '0;
            ae_s2_q <= '0;
            af_s2_q <= '0;
        end else begin
            ae_s1_q <= ae_s1_d;
            af_s1_q <= af_s1_d;
            ae_s2_q <= ae_s2_d;
            af_s2_q <= af_s2_d;
        end
    end

    assign almost_empty_flag = ae_s2_q;
    assign almost_full_flag = af_s2_q;

endmodule

/* testbench/rmc_config_capture_sva.sv */
// Concurrent checks for the reset-time configuration capture block.
// Assumes it is bound to rmc_config_capture and sees only its ports.
`timescale 1ns/1ps

module rmc_config_capture_chk
    import rmc_pkg::*;
#(
    parameter int NUM_QUEUES = RMC_NUM_QUEUES
) (
    // Clock, resets and straps.
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic [1:0] topology_select,
    input wire logic flag_timing_serial_in,
    input wire logic write_rate_select,
    input wire logic read_rate_select,
    input wire logic [1:0] write_width_select,
    input wire logic [1:0] read_width_select,
    input wire logic [1:0] offset_default_select,
    input wire logic [1:0] input_queue_select,
    input wire logic [1:0] output_queue_select,
    input wire logic [NUM_QUEUES-1:0] empty_level_raw,
    input wire logic [NUM_QUEUES-1:0] full_level_raw,
    // Captured configuration and flags.
    input wire logic mux_mode,
    input wire logic fall_through_timing,
    input wire logic write_ddr,
    input wire logic read_ddr,
    input wire logic prog_flag_sync,
    input wire logic [RMC_WIDTH_BITS_W-1:0] write_port_bits,
    input wire logic [RMC_WIDTH_BITS_W-1:0] read_port_bits,
    input wire logic [NUM_QUEUES*RMC_OFFSET_W-1:0] flag_offsets,
    input wire logic [1:0] write_queue,
    input wire logic [1:0] read_queue,
    input wire logic config_valid,
    input wire logic [NUM_QUEUES-1:0] almost_empty_flag,
    input wire logic [NUM_QUEUES-1:0] almost_full_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Width for a width code; restricted codes never reach here in legal use.
    function automatic logic [5:0] bits_of(input logic [1:0] c);
        return (c == RMC_WIDTH_X20) ? RMC_BITS_20 : (c == RMC_WIDTH_X40) ? RMC_BITS_40 : RMC_BITS_10;
    endfunction

    logic [9:0] ofs_exp;
    // Offset that the default select asks for.
    always_comb begin
        case (offset_default_select)
            RMC_OFS_SEL_63: ofs_exp = RMC_OFS_63;
            RMC_OFS_SEL_127: ofs_exp = RMC_OFS_127;
            RMC_OFS_SEL_1023: ofs_exp = RMC_OFS_1023;
            default: ofs_exp = RMC_OFS_7;
        endcase
    end

    chk_valid_after_release: assert property ($rose(master_reset_n) |-> ##2 config_valid)
        else $error("config_valid late after master reset");
    chk_topo_decode: assert property (!master_reset_n |=> mux_mode == ($past(topology_select) == RMC_TOPO_MUX))
        else $error("topology decode wrong");
    chk_timing_rates: assert property (!master_reset_n |=> {fall_through_timing, write_ddr, read_ddr} ==
        $past({flag_timing_serial_in, write_rate_select, read_rate_select})) else $error("timing or rate wrong");
    chk_offset_load: assert property (!master_reset_n |=> flag_offsets == {NUM_QUEUES{$past(ofs_exp)}})
        else $error("default offsets wrong");
    chk_read_width: assert property (!master_reset_n && topology_select == RMC_TOPO_MUX |=>
        read_port_bits == bits_of($past(read_width_select)) && write_port_bits == RMC_BITS_10)
        else $error("mux widths wrong");
    chk_write_width: assert property (!master_reset_n && topology_select != RMC_TOPO_MUX |=>
        write_port_bits == bits_of($past(write_width_select)) && read_port_bits == RMC_BITS_10)
        else $error("write widths wrong");
    chk_write_queue: assert property (!master_reset_n |=> write_queue ==
        (($past(topology_select) == RMC_TOPO_DEMUX) ? $past(input_queue_select) : 2'h0))
        else $error("initial write queue wrong");
    chk_read_queue: assert property (!master_reset_n |=> read_queue ==
        (($past(topology_select) == RMC_TOPO_MUX) ? $past(output_queue_select) : 2'h0))
        else $error("initial read queue wrong");
    chk_valid_low: assert property (!master_reset_n |=> !config_valid)
        else $error("config_valid high during master reset");
    chk_config_hold: assert property (master_reset_n && $past(master_reset_n) |->
        $stable(flag_offsets) && $stable(read_port_bits) && $stable(mux_mode)) else $error("config moved");
    chk_sync_flags: assert property (prog_flag_sync && $past(prog_flag_sync) && $past(prog_flag_sync, 2) |->
        almost_empty_flag == $past(empty_level_raw, 2) && almost_full_flag == $past(full_level_raw, 2))
        else $error("synchronous flag latency wrong");
    chk_async_flags: assert property (!prog_flag_sync && !$past(prog_flag_sync) |->
        almost_empty_flag == $past(empty_level_raw) && almost_full_flag == $past(full_level_raw))
        else $error("asynchronous flag latency wrong");

    cover property (config_valid && mux_mode);
    cover property (prog_flag_sync && |almost_full_flag);
    cover property (write_port_bits == RMC_BITS_40);
endmodule

bind rmc_config_capture rmc_config_capture_chk #(.NUM_QUEUES(NUM_QUEUES)) chk (.ref_clk, .rst_n,
    .master_reset_n, .topology_select, .flag_timing_serial_in, .write_rate_select, .read_rate_select,
    .write_width_select, .read_width_select, .offset_default_select, .input_queue_select, .output_queue_select,
    .empty_level_raw, .full_level_raw, .mux_mode, .fall_through_timing, .write_ddr, .read_ddr, .prog_flag_sync,
    .write_port_bits, .read_port_bits, .flag_offsets, .write_queue, .read_queue, .config_valid,
    .almost_empty_flag, .almost_full_flag);

/* testbench/rmc_strap_board.sv */
// Board model that drives master reset and the configuration straps.
// Assumes the bench calls apply and that ref_clk is shared with the device.
`timescale 1ns/1ps

module rmc_strap_board #(
    parameter int HOLD = 20
) (
    // Clock.
    input wire logic ref_clk,
    // Master reset and straps.
    output logic master_reset_n,
    output logic [1:0] topology_select,
    output logic flag_timing_serial_in,
    output logic write_rate_select,
    output logic read_rate_select,
    output logic prog_flag_timing_select,
    output logic [1:0] write_width_select,
    output logic [1:0] read_width_select,
    output logic [1:0] offset_default_select,
    output logic [1:0] input_queue_select,
    output logic [1:0] output_queue_select
);
    // Quiet board at time zero: no master reset, straps low.
    initial begin
        master_reset_n = 1'b1;
        apply_straps(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 4'h0);
    end

    // Sets every strap in one step so that no strap lags another.
    task automatic apply_straps(input logic [1:0] tp, w, fs, qi, qo, input logic [3:0] b);
        begin
            {topology_select, write_width_select, read_width_select} = {tp, w, w};
            {offset_default_select, input_queue_select, output_queue_select} = {fs, qi, qo};
            {flag_timing_serial_in, write_rate_select, read_rate_select, prog_flag_timing_select} = b;
        end
    endtask

    // Pulses master reset for HOLD cycles, 200 ns at the 10 ns clock.
    task automatic apply(input logic [1:0] tp, w, fs, qi, qo, input logic [3:0] b);
        begin
            @(posedge ref_clk);
            #1;
            master_reset_n = 1'b0;
            apply_straps(tp, w, fs, qi, qo, b);
            repeat (HOLD) @(posedge ref_clk);
            #1;
            master_reset_n = 1'b1;
            // Straps wander once released, so a device that keeps sampling them is caught.
            apply_straps(~tp, ~w, ~fs, ~qi, ~qo, ~b);
        end
    endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the reset-time configuration capture block.
// Assumes the strap board model drives master reset and all straps.
`timescale 1ns/1ps

module testbench;
    import rmc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic master_reset_n, flag_timing_serial_in, write_rate_select, read_rate_select, prog_flag_timing_select;
    logic [1:0] topology_select, write_width_select, read_width_select;
    logic [1:0] offset_default_select, input_queue_select, output_queue_select;
    logic [3:0] empty_level_raw = 4'h0;
    logic [3:0] full_level_raw = 4'h0;
    logic mux_mode, demux_mode, broadcast_mode, fall_through_timing, write_ddr, read_ddr;
    logic prog_flag_sync, config_restricted, config_valid;
    logic [5:0] write_port_bits, read_port_bits;
    logic [39:0] flag_offsets;
    logic [1:0] write_queue, read_queue, tp, w;
    logic [3:0] almost_empty_flag, almost_full_flag, b;
    int fails = 0;
    int total_checks = 0;

    // Free-running 100 MHz reference clock.
    always #5 ref_clk = ~ref_clk;

    rmc_config_capture dut (.ref_clk, .rst_n, .master_reset_n, .topology_select, .flag_timing_serial_in,
        .write_rate_select, .read_rate_select, .prog_flag_timing_select, .write_width_select,
        .read_width_select, .offset_default_select, .input_queue_select, .output_queue_select,
        .empty_level_raw, .full_level_raw, .mux_mode, .demux_mode, .broadcast_mode, .fall_through_timing,
        .write_ddr, .read_ddr, .prog_flag_sync, .write_port_bits, .read_port_bits, .flag_offsets,
        .write_queue, .read_queue, .config_restricted, .config_valid, .almost_empty_flag, .almost_full_flag);
    rmc_strap_board board (.ref_clk, .master_reset_n, .topology_select, .flag_timing_serial_in,
        .write_rate_select, .read_rate_select, .prog_flag_timing_select, .write_width_select,
        .read_width_select, .offset_default_select, .input_queue_select, .output_queue_select);

    // Width and offset that the rules assign to each code.
    function automatic logic [5:0] w_bits(input logic [1:0] c);
        return (c == 2'h1) ? RMC_BITS_20 : (c == 2'h2) ? RMC_BITS_40 : RMC_BITS_10;
    endfunction
    function automatic logic [9:0] ofs(input logic [1:0] c);
        return (c == 2'h0) ? 10'h007 : (c == 2'h1) ? 10'h03f : (c == 2'h2) ? 10'h07f : 10'h3ff;
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        begin
            total_checks++;
            if (got !== exp) begin
                fails++;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim;
        begin
            $display("checks=%0d fails=%0d", total_checks, fails);
            if (fails == 0 && total_checks > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask

    // Six captures cover every topology and width code except restricted, and all offset codes.
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        check({config_valid, demux_mode, mux_mode, write_port_bits, read_port_bits}, {2'b01, 1'b0, RMC_RST_BITS, RMC_RST_BITS});
        check(flag_offsets, {4{RMC_RST_OFS}});
        for (int i = 0; i < 6; i++) begin
            tp = 2'(i % 3);
            w = 2'(i / 2);
            b = {i[0], i[1], i[2], ~i[0]};
            board.apply(tp, w, 2'(i % 4), 2'(i % 4), 2'((i + 2) % 4), b);
            repeat (3) @(posedge ref_clk);
            #1;
            check(config_valid, 1'b1);
            check({mux_mode, demux_mode, broadcast_mode}, {tp == 2'h2, tp == 2'h0, tp == 2'h1});
            check({fall_through_timing, write_ddr, read_ddr, prog_flag_sync}, b);
            check(write_port_bits, (tp == 2'h2) ? RMC_BITS_10 : w_bits(w));
            check(read_port_bits, (tp == 2'h2) ? w_bits(w) : RMC_BITS_10);
            check(flag_offsets, {4{ofs(2'(i % 4))}});
            check({write_queue, read_queue}, {(tp == 2'h0) ? 2'(i % 4) : 2'h0, (tp == 2'h2) ? 2'((i + 2) % 4) : 2'h0});
            check(config_restricted, 1'b0);
            $display("config test %0d done", i);
        end
        // Flag latency: one stage when asynchronous, two when synchronous.
        for (int s = 0; s < 2; s++) begin
            board.apply(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 4'(s));
            repeat (3) @(posedge ref_clk);
            #1;
            empty_level_raw = 4'h5;
            full_level_raw = 4'ha;
            @(posedge ref_clk);
            #1;
            check({almost_empty_flag, almost_full_flag}, (s == 1) ? 8'h00 : 8'h5a);
            @(posedge ref_clk);
            #1;
            check({almost_empty_flag, almost_full_flag}, 8'h5a);
            empty_level_raw = 4'h0;
            full_level_raw = 4'h0;
            repeat (2) @(posedge ref_clk);
            $display("flag test %0d done", s);
        end
        end_sim();
    end

    // Watchdog, well beyond the few hundred cycles the tests need.
    initial begin
        repeat (2000) @(posedge ref_clk);
        fails++;
        end_sim();
    end
endmodule
